//--- hw/mir_regs.sv
// mode control, bus configuration and first-level interrupt registers
// assumes the serial front end presents one-cycle read/write strobes on core_clk,
// and that detector events arrive as one-cycle pulses on core_clk
`timescale 1ns/1ps

module mir_regs #(
  parameter int unsigned SUPPLY_FLAGS = mir_pkg::SUPPLY_W
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // register port
  input mir_pkg::mir_req_t reg_req,
  output logic [mir_pkg::DATA_W-1:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // fault and wake detectors
  input mir_pkg::mir_bus_evt_t bus_evt,
  input mir_pkg::mir_wake_evt_t wake_evt,
  input wire logic [SUPPLY_FLAGS-1:0] supply_evt,
  // transceiver and supply control
  output mir_pkg::mir_mode_t mode_req_q,
  output mir_pkg::mir_mode_t dev_state_q,
  output logic slew_high_q,
  output logic [mir_pkg::DATA_W-1:0] dev_cfg_q,
  // interrupt pin
  output logic interrupt_out_n
);

  // width of the request and state fields
  localparam int unsigned MODE_W = $bits(mir_pkg::mir_mode_t);

  // reset release through two flops; only the second flop is used downstream
  logic rst_meta_q;
  logic rst_n_q;
  logic rst_meta_d;
  logic rst_n_d;

  always_comb begin
    rst_meta_d = 1'b1;
    rst_n_d = rst_meta_q;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= rst_meta_d;
      rst_n_q <= rst_n_d;
    end
  end

  // decode
  logic wr_cfg;
  logic wr_mode;
  logic wr_bus_src;
  logic wr_wake_src;
  logic wr_supply_src;

  always_comb begin
    wr_cfg = reg_req.wr && (reg_req.addr == mir_pkg::ADDR_DEV_CFG);
    wr_mode = reg_req.wr && (reg_req.addr == mir_pkg::ADDR_MODE_CTRL);
    wr_bus_src = reg_req.wr && (reg_req.addr == mir_pkg::ADDR_BUS_FAIL_SRC);
    wr_wake_src = reg_req.wr && (reg_req.addr == mir_pkg::ADDR_WAKE_TEMP_SRC);
    wr_supply_src = reg_req.wr && (reg_req.addr == mir_pkg::ADDR_SUPPLY_SRC);
  end

  // configuration and mode request
  logic [mir_pkg::DATA_W-1:0] dev_cfg_d;
  mir_pkg::mir_mode_t mode_req_d;
  logic slew_high_d;

  always_comb begin
    dev_cfg_d = dev_cfg_q;
    mode_req_d = mode_req_q;
    if (wr_cfg) begin
      dev_cfg_d = reg_req.wdata;
    end
    if (wr_mode) begin
      // only the request field is writable; state and reserved bits ignored
      mode_req_d = mir_pkg::mir_mode_t'(reg_req.wdata[mir_pkg::MODE_REQ_LSB +: MODE_W]);
    end
    slew_high_d = dev_cfg_d[mir_pkg::CFG_SLEW_BIT];
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dev_cfg_q <= mir_pkg::RST_DEV_CFG;
      mode_req_q <= mir_pkg::MIR_MODE_STANDBY;
      slew_high_q <= mir_pkg::RST_DEV_CFG[mir_pkg::CFG_SLEW_BIT];
    end else if (clk_en) begin
      dev_cfg_q <= dev_cfg_d;
      mode_req_q <= mode_req_d;
      slew_high_q <= slew_high_d;
    end
  end

  // present device state
  // sleep removes the host's supply, so the readback keeps the last awake state
  mir_pkg::mir_mode_t dev_state_d;
  logic wake_seen;

  // either wake source ends sleep; temperature events do not
  always_comb begin
    wake_seen = wake_evt.local_wake || wake_evt.remote_wake;
  end

  always_comb begin
    dev_state_d = dev_state_q;
    case (mode_req_q)
      mir_pkg::MIR_MODE_STANDBY: begin
        dev_state_d = mir_pkg::MIR_MODE_STANDBY;
      end
      mir_pkg::MIR_MODE_NORMAL: begin
        dev_state_d = mir_pkg::MIR_MODE_NORMAL;
      end
      mir_pkg::MIR_MODE_RX_ONLY: begin
        dev_state_d = mir_pkg::MIR_MODE_RX_ONLY;
      end
      mir_pkg::MIR_MODE_SLEEP: begin
        dev_state_d = dev_state_q;
      end
      default: begin
        dev_state_d = mir_pkg::MIR_MODE_STANDBY;
      end
    endcase
    // a wake event brings the device back to standby
    if (mode_req_q == mir_pkg::MIR_MODE_SLEEP && wake_seen) begin
      dev_state_d = mir_pkg::MIR_MODE_STANDBY;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dev_state_q <= mir_pkg::MIR_MODE_STANDBY;
    end else if (clk_en) begin
      dev_state_q <= dev_state_d;
    end
  end

  // sticky source flags, cleared by writing one
  logic [mir_pkg::BUS_FAIL_W-1:0] bus_src_q;
  logic [mir_pkg::WAKE_TEMP_W-1:0] wake_src_q;
  logic [SUPPLY_FLAGS-1:0] supply_src_q;
  logic [mir_pkg::BUS_FAIL_W-1:0] bus_clr;
  logic [mir_pkg::WAKE_TEMP_W-1:0] wake_clr;
  logic [SUPPLY_FLAGS-1:0] supply_clr;

  always_comb begin
    bus_clr = wr_bus_src ? reg_req.wdata : '0;
    wake_clr = wr_wake_src ? reg_req.wdata[mir_pkg::WAKE_TEMP_W-1:0] : '0;
    supply_clr = wr_supply_src ? reg_req.wdata[SUPPLY_FLAGS-1:0] : '0;
  end

  // struct order matches bit 7 down to bit 0
  mir_flag_bank #(
    .WIDTH(mir_pkg::BUS_FAIL_W)
  ) u_bus_src (
    .clk(core_clk),
    .rst_n(rst_n_q),
    .clk_en(clk_en),
    .set_i(bus_evt),
    .clr_i(bus_clr),
    .flags_q(bus_src_q)
  );

  mir_flag_bank #(
    .WIDTH(mir_pkg::WAKE_TEMP_W)
  ) u_wake_src (
    .clk(core_clk),
    .rst_n(rst_n_q),
    .clk_en(clk_en),
    .set_i(wake_evt),
    .clr_i(wake_clr),
    .flags_q(wake_src_q)
  );

  mir_flag_bank #(
    .WIDTH(SUPPLY_FLAGS)
  ) u_supply_src (
    .clk(core_clk),
    .rst_n(rst_n_q),
    .clk_en(clk_en),
    .set_i(supply_evt),
    .clr_i(supply_clr),
    .flags_q(supply_src_q)
  );

  // summary and interrupt pin
  logic [mir_pkg::DATA_W-1:0] summary;

  always_comb begin
    summary = mir_pkg::RST_ZERO;
    summary[mir_pkg::SUM_BUS_FAIL_BIT] = |bus_src_q;
    summary[mir_pkg::SUM_WAKE_TEMP_BIT] = |wake_src_q;
    summary[mir_pkg::SUM_SUPPLY_BIT] = |supply_src_q;
  end

  // driven straight from flag flops so the pin follows without a cycle of lag
  assign interrupt_out_n = ~(|summary);

  // readback words; reserved and unused positions read as zero
  logic [mir_pkg::DATA_W-1:0] mode_word;
  logic [mir_pkg::DATA_W-1:0] wake_word;
  logic [mir_pkg::DATA_W-1:0] supply_word;

  always_comb begin
    mode_word = mir_pkg::RST_ZERO;
    mode_word[mir_pkg::MODE_REQ_LSB +: MODE_W] = mode_req_q;
    mode_word[mir_pkg::MODE_STATE_LSB +: MODE_W] = dev_state_q;
    wake_word = mir_pkg::RST_ZERO;
    wake_word[mir_pkg::WAKE_TEMP_W-1:0] = wake_src_q;
    supply_word = mir_pkg::RST_ZERO;
    supply_word[SUPPLY_FLAGS-1:0] = supply_src_q;
  end

  // read path
  logic [mir_pkg::DATA_W-1:0] rdata_mux;
  logic [mir_pkg::DATA_W-1:0] reg_rdata_d;
  logic reg_rvalid_d;

  always_comb begin
    rdata_mux = mir_pkg::RST_ZERO;
    case (reg_req.addr)
      mir_pkg::ADDR_DEV_CFG: begin
        rdata_mux = dev_cfg_q;
      end
      mir_pkg::ADDR_MODE_CTRL: begin
        rdata_mux = mode_word;
      end
      mir_pkg::ADDR_INT_SUMMARY: begin
        rdata_mux = summary;
      end
      mir_pkg::ADDR_BUS_FAIL_SRC: begin
        rdata_mux = bus_src_q;
      end
      mir_pkg::ADDR_WAKE_TEMP_SRC: begin
        rdata_mux = wake_word;
      end
      mir_pkg::ADDR_SUPPLY_SRC: begin
        rdata_mux = supply_word;
      end
      default: begin
        rdata_mux = mir_pkg::RST_ZERO;
      end
    endcase
    reg_rdata_d = reg_req.rd ? rdata_mux : reg_rdata_q;
    reg_rvalid_d = reg_req.rd;
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata_q <= mir_pkg::RST_ZERO;
      reg_rvalid_q <= 1'b0;
    end else if (clk_en) begin
      reg_rdata_q <= reg_rdata_d;
      reg_rvalid_q <= reg_rvalid_d;
    end
  end

endmodule

//--- hw/mir_pkg.sv
// package for the mode control and first-level interrupt registers
// assumes one 8-bit register port from the host serial front end
package mir_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] ADDR_DEV_CFG = 8'h05;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h06;
  localparam logic [7:0] ADDR_INT_SUMMARY = 8'h07;
  localparam logic [7:0] ADDR_BUS_FAIL_SRC = 8'h08;
  localparam logic [7:0] ADDR_WAKE_TEMP_SRC = 8'h09;
  localparam logic [7:0] ADDR_SUPPLY_SRC = 8'h0a;

  // reset values
  localparam logic [7:0] RST_DEV_CFG = 8'h6d;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // field positions
  localparam int unsigned CFG_SLEW_BIT = 0;
  localparam int unsigned MODE_REQ_LSB = 0;
  localparam int unsigned MODE_STATE_LSB = 4;
  localparam int unsigned SUM_BUS_FAIL_BIT = 0;
  localparam int unsigned SUM_WAKE_TEMP_BIT = 1;
  localparam int unsigned SUM_SUPPLY_BIT = 2;

  // source register widths and their bit positions
  localparam int unsigned BUS_FAIL_W = 8;
  localparam int unsigned WAKE_TEMP_W = 4;
  localparam int unsigned SUPPLY_W = 8;
  localparam int unsigned WT_REMOTE_WAKE = 0;
  localparam int unsigned WT_LOCAL_WAKE = 1;
  localparam int unsigned WT_TEMP_WARN = 2;
  localparam int unsigned WT_TEMP_RECOVER = 3;

  // mode request and state encodings
  typedef enum logic [1:0] {
    MIR_MODE_STANDBY = 2'h0,
    MIR_MODE_NORMAL = 2'h1,
    MIR_MODE_RX_ONLY = 2'h2,
    MIR_MODE_SLEEP = 2'h3
  } mir_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mir_req_t;

  typedef struct packed {
    logic bus_dominant_clamp;
    logic txd_rxd_short;
    logic rxd_recessive_clamp;
    logic txd_dominant_clamp;
    logic canl_short_vcc;
    logic canl_short_gnd;
    logic canh_short_gnd;
    logic canh_short_vcc;
  } mir_bus_evt_t;

  typedef struct packed {
    logic temp_recovered;
    logic temp_warning;
    logic local_wake;
    logic remote_wake;
  } mir_wake_evt_t;

endpackage

//--- hw/mir_flag_bank.sv
// bank of sticky event flags, one flop per bit
// assumes set and clear are single-cycle strobes in the core_clk domain
`timescale 1ns/1ps
module mir_flag_bank #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // strobes
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  // state
  output logic [WIDTH-1:0] flags_q
);

  logic [WIDTH-1:0] flags_d;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    // set beats a clear in the same cycle so no event is lost
    always_comb begin
      flags_d[i] = flags_q[i];
      if (clr_i[i]) begin
        flags_d[i] = 1'b0;
      end
      if (set_i[i]) begin
        flags_d[i] = 1'b1;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        flags_q[i] <= 1'b0;
      end else if (clk_en) begin
        flags_q[i] <= flags_d[i];
      end
    end
  end

endmodule

//--- verif/mir_regs_props.sv
// concurrent checks on the mode and interrupt register block
// assumes bind to mir_regs; watches its ports only
`timescale 1ns/1ps
module mir_regs_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // register port
  input mir_pkg::mir_req_t reg_req,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  // events and outputs
  input mir_pkg::mir_bus_evt_t bus_evt,
  input mir_pkg::mir_wake_evt_t wake_evt,
  input wire logic [7:0] supply_evt,
  input mir_pkg::mir_mode_t mode_req_q,
  input mir_pkg::mir_mode_t dev_state_q,
  input wire logic slew_high_q,
  input wire logic [7:0] dev_cfg_q,
  input wire logic interrupt_out_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  mode_write_a: assert property (reg_req.wr && clk_en && reg_req.addr == 8'h06 |=> mode_req_q == $past(reg_req.wdata[1:0]))
    else $error("mode request not taken from write");
  state_follow_a: assert property (mode_req_q != 2'h3 && clk_en |=> dev_state_q == $past(mode_req_q))
    else $error("state does not follow request");
  state_legal_a: assert property (dev_state_q != 2'h3)
    else $error("state shows sleep code");
  mode_rsvd_a: assert property (reg_req.rd && clk_en && reg_req.addr == 8'h06 |=> reg_rdata_q[7:6] == 2'h0 && reg_rdata_q[3:2] == 2'h0)
    else $error("mode reserved bits nonzero");
  slew_cfg_a: assert property (slew_high_q == dev_cfg_q[0])
    else $error("slew output differs from config bit");
  sum_rsvd_a: assert property (reg_req.rd && clk_en && reg_req.addr == 8'h07 |=> reg_rdata_q[7:3] == 5'h00)
    else $error("summary reserved bits nonzero");
  wake_rsvd_a: assert property (reg_req.rd && clk_en && reg_req.addr == 8'h09 |=> reg_rdata_q[7:4] == 4'h0)
    else $error("wake source reserved bits nonzero");
  pin_assert_a: assert property (bus_evt != 8'h00 && clk_en |=> !interrupt_out_n)
    else $error("interrupt pin not low after event");
  src_pin_a: assert property ((wake_evt != 4'h0 || supply_evt != 8'h00) && clk_en |=> !interrupt_out_n)
    else $error("interrupt pin not low after wake or supply event");
  pin_release_a: assert property ($rose(interrupt_out_n) |-> $past(reg_req.wr))
    else $error("interrupt pin released without host write");
  read_valid_a: assert property (reg_req.rd && clk_en |=> reg_rvalid_q ##1
    (!reg_rvalid_q || $past(reg_req.rd) || !$past(clk_en)))
    else $error("read valid not a single pulse");
endmodule
bind mir_regs mir_regs_props mir_regs_props_i (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
  .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .bus_evt(bus_evt),
  .wake_evt(wake_evt), .supply_evt(supply_evt),
  .mode_req_q(mode_req_q), .dev_state_q(dev_state_q), .slew_high_q(slew_high_q), .dev_cfg_q(dev_cfg_q),
  .interrupt_out_n(interrupt_out_n));

//--- verif/mir_host_model.sv
// host side of the register port: one strobe per access
// assumes read data one cycle after the taken edge
`timescale 1ns/1ps
module mir_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output mir_pkg::mir_req_t reg_req,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q
);
  initial reg_req = '0;
  // released lines show the inverse so stale values never match
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd_o);
    @(posedge core_clk);
    reg_req <= {w, !w, a, wd};
    @(posedge core_clk);
    reg_req <= {1'b0, 1'b0, ~a, ~wd};
    @(negedge core_clk);
    rd_o = (w || reg_rvalid_q !== 1'b1) ? 8'hxx : reg_rdata_q;
  endtask
endmodule

//--- verif/mir_regs_bench.sv
// self-checking bench for the mode and interrupt registers
// assumes mir_host_model issues all register accesses
`timescale 1ns/1ps
module mir_regs_bench;
  logic core_clk = 0, arst_n = 0, clk_en = 1, interrupt_out_n, reg_rvalid_q, slew_high_q;
  mir_pkg::mir_req_t reg_req;
  mir_pkg::mir_bus_evt_t bus_evt = '0;
  mir_pkg::mir_wake_evt_t wake_evt = '0;
  logic [7:0] supply_evt = 8'h00, reg_rdata_q, dev_cfg_q, d;
  mir_pkg::mir_mode_t mode_req_q, dev_state_q;
  int num_errors = 0, total_checks = 0, cycles = 0;
  always #10 core_clk = ~core_clk;
  mir_regs mir_regs_i (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .bus_evt(bus_evt), .wake_evt(wake_evt),
    .supply_evt(supply_evt), .mode_req_q(mode_req_q), .dev_state_q(dev_state_q), .slew_high_q(slew_high_q),
    .dev_cfg_q(dev_cfg_q), .interrupt_out_n(interrupt_out_n));
  mir_host_model mir_host_model_i (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    mir_host_model_i.access(1'b1, a, v, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    mir_host_model_i.access(1'b0, a, 8'h00, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  // pulse one detector bit, find it in summary and source, clear it
  task automatic evt(input int sel, input int i, input logic [7:0] a, input logic [7:0] sum);
    @(posedge core_clk);
    if (sel == 0) bus_evt <= 8'h01 << i;
    else if (sel == 1) wake_evt <= 4'h1 << i;
    else supply_evt <= 8'h01 << i;
    @(posedge core_clk);
    {bus_evt, wake_evt, supply_evt} <= '0;
    @(negedge core_clk);
    chk("pin", {7'h00, interrupt_out_n}, 8'h00);
    rd(8'h07, sum);
    rd(a, 8'h01 << i);
    rd(a, 8'h01 << i);
    wr(a, 8'h01 << i);
    rd(a, 8'h00);
    rd(8'h07, 8'h00);
    chk("pin", {7'h00, interrupt_out_n}, 8'h01);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 6000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("cfg", dev_cfg_q, 8'h6d);
    for (int a = 6; a < 11; a++) rd(a[7:0], 8'h00);
    chk("pin", {7'h00, interrupt_out_n}, 8'h01);
    $display("reset test done");
    for (int m = 0; m < 3; m++) begin
      wr(8'h06, 8'hfc | m[7:0]);
      rd(8'h06, {2'h0, m[1:0], 2'h0, m[1:0]});
    end
    wr(8'h06, 8'h03);
    rd(8'h06, 8'h23);
    wr(8'h05, 8'h00);
    chk("slew", {7'h00, slew_high_q}, 8'h00);
    wr(8'h05, 8'h01);
    chk("slew", {7'h00, slew_high_q}, 8'h01);
    rd(8'h05, 8'h01);
    $display("mode test done");
    for (int i = 0; i < 8; i++) evt(0, i, 8'h08, 8'h01);
    for (int i = 0; i < 4; i++) evt(1, i, 8'h09, 8'h02);
    for (int i = 0; i < 8; i++) evt(2, i, 8'h0a, 8'h04);
    rd(8'h06, 8'h03);
    // event pulse lands on the same edge as its clear: the set must win
    fork
      wr(8'h08, 8'h80);
      begin
        @(posedge core_clk);
        bus_evt <= 8'h80;
        @(posedge core_clk);
        bus_evt <= '0;
      end
    join
    rd(8'h08, 8'h80);
    wr(8'h08, 8'h80);
    rd(8'h08, 8'h00);
    $display("event test done");
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h00);
    rd(8'h20, 8'h00);
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(8'h06, 8'h01);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(8'h06, 8'h03);
    $display("refusal test done");
    report_and_stop();
  end
endmodule
